// ===== hw/mcc_defs.svh
// Constants for the collision and octet statistics counters
// Behaviour
// - Count frames sent after two-plus collisions.
// - Counters wrap to zero, never saturate.
// - Reaching high-water raises the harvest flag.
// - Count only when enabled and unmasked.
// - Add good received frame octets.
// - Skip errored, too-long or overrun receives.
// - Add good transmitted frame octets.
// - Octet counts include a stripped or inserted tag.
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH
`define MCC_OFS_COLL        8'hC8
`define MCC_OFS_RX_OCT      8'hCC
`define MCC_OFS_TX_OCT      8'hD0
`define MCC_IDX_COLL        0
`define MCC_IDX_RX_OCT      1
`define MCC_IDX_TX_OCT      2
`define MCC_NUM_CNT         3
`define MCC_HIGH_WATER      32'hC000_0000
`define MCC_RESET_VAL       32'h0000_0000
`define MCC_VLAN_OCTETS     32'h0000_0004
`define MCC_MIN_MULTI_COLL  5'h02
`endif

// ===== hw/mcc_pkg.sv
// Types for the collision and octet statistics counters
package mcc_pkg;
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [4:0]  coll_cnt;
    logic        vlan_insert;
    logic [15:0] octets;
  } mcc_tx_event_type;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic        too_long;
    logic        fcs_err;
    logic        len_err;
    logic        align_err;
    logic        overrun;
    logic        vlan_strip;
    logic [15:0] octets;
  } mcc_rx_event_type;
endpackage

// ===== hw/mcc_counter.sv
// One wrapping statistics counter with host preset and high-water detect
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             inc_en,
  input  wire logic [WIDTH-1:0] inc_amt,
  output logic      [WIDTH-1:0] count,
  output logic                  hw_hit
);
  localparam logic [WIDTH-1:0] HIGH_WATER = WIDTH'(`MCC_HIGH_WATER);

  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic [WIDTH-1:0] base;

  always_comb begin
    base      = wr_en ? wr_data : count_ff;
    nxt_count = inc_en ? base + inc_amt : base;
    hw_hit    = inc_en && (base < HIGH_WATER) && (nxt_count >= HIGH_WATER);
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_ff <= WIDTH'(`MCC_RESET_VAL);
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_wrap_to_zero: assert property (
    (!wr_en && inc_en && inc_amt == WIDTH'(1) && count_ff == '1) |=> count_ff == '0)
    else $error("counter did not wrap to zero");
  a_host_preset: assert property (
    (wr_en && !inc_en) |=> count_ff == $past(wr_data))
    else $error("host write not stored");
  a_idle_stable: assert property (
    (!wr_en && !inc_en) |=> $stable(count_ff))
    else $error("counter moved without cause");
endmodule

// ===== hw/mcc_stats_top.sv
// Multi-collision and good octet statistics counters with register port
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_stats_top #(
  parameter int WIDTH = 32
) (
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     global_stats_enable,
  input  wire logic [`MCC_NUM_CNT-1:0]  counter_mask_reg,
  input  wire mcc_pkg::mcc_tx_event_type tx_evt,
  input  wire mcc_pkg::mcc_rx_event_type rx_evt,
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [WIDTH-1:0]         reg_wdata,
  output logic      [WIDTH-1:0]         reg_rdata,
  output logic                          reg_rvalid,
  output logic                          stats_harvest_flag
);
  logic [`MCC_NUM_CNT-1:0] sel;
  logic [`MCC_NUM_CNT-1:0] wr_en;
  logic [`MCC_NUM_CNT-1:0] inc_en;
  logic [`MCC_NUM_CNT-1:0] hit;
  logic [`MCC_NUM_CNT-1:0] gate;
  logic [WIDTH-1:0]        inc_amt [`MCC_NUM_CNT];
  logic [WIDTH-1:0]        count   [`MCC_NUM_CNT];
  logic                    rx_good;
  logic                    tx_good;
  logic                    multi_coll;
  logic [WIDTH-1:0]        rx_len;
  logic [WIDTH-1:0]        tx_len;
  logic [WIDTH-1:0]        rdata_ff;
  logic [WIDTH-1:0]        nxt_rdata;
  logic                    rvalid_ff;
  logic                    nxt_rvalid;
  logic                    harvest_ff;
  logic                    nxt_harvest;

  always_comb begin
    sel[`MCC_IDX_COLL]   = (reg_addr == `MCC_OFS_COLL);
    sel[`MCC_IDX_RX_OCT] = (reg_addr == `MCC_OFS_RX_OCT);
    sel[`MCC_IDX_TX_OCT] = (reg_addr == `MCC_OFS_TX_OCT);
    wr_en = reg_wr ? sel : '0;
    gate  = global_stats_enable ? ~counter_mask_reg : '0;
    multi_coll = tx_evt.coll_cnt >= `MCC_MIN_MULTI_COLL;
    tx_good = tx_evt.valid && tx_evt.ok;
    rx_good = rx_evt.valid && rx_evt.ok && !rx_evt.too_long && !rx_evt.fcs_err
              && !rx_evt.len_err && !rx_evt.align_err && !rx_evt.overrun;
    rx_len = WIDTH'(rx_evt.octets)
             + (rx_evt.vlan_strip ? WIDTH'(`MCC_VLAN_OCTETS) : '0);
    tx_len = WIDTH'(tx_evt.octets)
             + (tx_evt.vlan_insert ? WIDTH'(`MCC_VLAN_OCTETS) : '0);
    inc_en[`MCC_IDX_COLL]    = gate[`MCC_IDX_COLL] && tx_good && multi_coll;
    inc_amt[`MCC_IDX_COLL]   = WIDTH'(1);
    inc_en[`MCC_IDX_RX_OCT]  = gate[`MCC_IDX_RX_OCT] && rx_good;
    inc_amt[`MCC_IDX_RX_OCT] = rx_len;
    inc_en[`MCC_IDX_TX_OCT]  = gate[`MCC_IDX_TX_OCT] && tx_good;
    inc_amt[`MCC_IDX_TX_OCT] = tx_len;
  end

  for (genvar i = 0; i < `MCC_NUM_CNT; i++) begin : g_cnt
    mcc_counter #(
      .WIDTH (WIDTH)
    ) u_cnt (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .wr_en   (wr_en[i]),
      .wr_data (reg_wdata),
      .inc_en  (inc_en[i]),
      .inc_amt (inc_amt[i]),
      .count   (count[i]),
      .hw_hit  (hit[i])
    );
  end

  always_comb begin
    nxt_harvest = |hit;
    nxt_rvalid  = reg_rd;
    nxt_rdata   = '0;
    if (reg_rd) begin
      for (int j = 0; j < `MCC_NUM_CNT; j++) begin
        if (sel[j]) begin
          nxt_rdata = count[j];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff   <= '0;
      rvalid_ff  <= 1'b0;
      harvest_ff <= 1'b0;
    end else begin
      rdata_ff   <= nxt_rdata;
      rvalid_ff  <= nxt_rvalid;
      harvest_ff <= nxt_harvest;
    end
  end

  assign reg_rdata          = rdata_ff;
  assign reg_rvalid         = rvalid_ff;
  assign stats_harvest_flag = harvest_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  localparam logic [WIDTH-1:0] HW = WIDTH'(`MCC_HIGH_WATER);

  sequence s_tx_cross;
    !wr_en[`MCC_IDX_TX_OCT] && inc_en[`MCC_IDX_TX_OCT] && count[`MCC_IDX_TX_OCT] < HW
      && WIDTH'(count[`MCC_IDX_TX_OCT] + tx_len) >= HW;
  endsequence
  sequence s_flag_once;
    stats_harvest_flag ##1 !stats_harvest_flag || $past(|hit, 1);
  endsequence
  sequence s_coll_cross;
    !wr_en[`MCC_IDX_COLL] && inc_en[`MCC_IDX_COLL] && count[`MCC_IDX_COLL] < HW
      && WIDTH'(count[`MCC_IDX_COLL] + WIDTH'(1)) >= HW;
  endsequence
  sequence s_rx_cross;
    !wr_en[`MCC_IDX_RX_OCT] && inc_en[`MCC_IDX_RX_OCT] && count[`MCC_IDX_RX_OCT] < HW
      && WIDTH'(count[`MCC_IDX_RX_OCT] + rx_len) >= HW;
  endsequence

  a_multi_coll_count: assert property (
    (tx_good && multi_coll && global_stats_enable && !counter_mask_reg[`MCC_IDX_COLL]
     && !wr_en[`MCC_IDX_COLL]) |=> count[`MCC_IDX_COLL] == $past(count[`MCC_IDX_COLL]) + 1)
    else $error("multi-collision frame not counted");
  a_single_coll_skip: assert property (
    (!wr_en[`MCC_IDX_COLL] && !(tx_good && multi_coll)) |=> $stable(count[`MCC_IDX_COLL]))
    else $error("collision counter moved on a non-multi frame");
  a_harvest_raise: assert property (
    s_tx_cross |=> s_flag_once)
    else $error("harvest flag missing after high-water");
  a_harvest_cause: assert property (
    stats_harvest_flag |-> $past(|hit))
    else $error("harvest flag without a crossing");
  a_global_gate: assert property (
    (!global_stats_enable && !reg_wr) |=> ($stable(count[`MCC_IDX_COLL])
     && $stable(count[`MCC_IDX_RX_OCT]) && $stable(count[`MCC_IDX_TX_OCT])))
    else $error("counter moved while disabled");
  a_mask_gate: assert property (
    (counter_mask_reg[`MCC_IDX_RX_OCT] && !wr_en[`MCC_IDX_RX_OCT])
    |=> $stable(count[`MCC_IDX_RX_OCT]))
    else $error("masked counter moved");
  a_rx_octet_add: assert property (
    (gate[`MCC_IDX_RX_OCT] && rx_good && !wr_en[`MCC_IDX_RX_OCT])
    |=> count[`MCC_IDX_RX_OCT] == $past(count[`MCC_IDX_RX_OCT]) + $past(rx_len))
    else $error("received octets not added");
  a_rx_error_skip: assert property (
    (rx_evt.valid && (rx_evt.fcs_err || rx_evt.overrun || rx_evt.too_long)
     && !wr_en[`MCC_IDX_RX_OCT]) |=> $stable(count[`MCC_IDX_RX_OCT]))
    else $error("errored frame counted");
  a_tx_octet_vlan: assert property (
    (gate[`MCC_IDX_TX_OCT] && tx_good && tx_evt.vlan_insert && !wr_en[`MCC_IDX_TX_OCT])
    |=> count[`MCC_IDX_TX_OCT] == $past(count[`MCC_IDX_TX_OCT])
        + WIDTH'($past(tx_evt.octets)) + WIDTH'(`MCC_VLAN_OCTETS))
    else $error("transmitted octets or tag not added");
  a_read_back: assert property (
    (reg_wr && sel[`MCC_IDX_COLL] && !inc_en[`MCC_IDX_COLL])
    ##1 (reg_rd && sel[`MCC_IDX_COLL] && !reg_wr) |=> reg_rvalid
    && reg_rdata == $past(reg_wdata, 2))
    else $error("written value not read back");

  // Harvest flag on the other counters
  a_harvest_coll: assert property (
    s_coll_cross |=> s_flag_once)
    else $error("harvest flag missing after collision high-water");
  a_harvest_rx: assert property (
    s_rx_cross |=> s_flag_once)
    else $error("harvest flag missing after receive high-water");
  a_harvest_single: assert property (
    (stats_harvest_flag && !(|hit)) |=> !stats_harvest_flag)
    else $error("harvest flag held too long");
  a_write_no_flag: assert property (
    (reg_wr && !(|inc_en)) |=> !stats_harvest_flag)
    else $error("host write raised the harvest flag");

  // Mask gating on the other counters
  a_coll_mask_gate: assert property (
    (counter_mask_reg[`MCC_IDX_COLL] && !wr_en[`MCC_IDX_COLL])
    |=> $stable(count[`MCC_IDX_COLL]))
    else $error("masked collision counter moved");
  a_tx_mask_gate: assert property (
    (counter_mask_reg[`MCC_IDX_TX_OCT] && !wr_en[`MCC_IDX_TX_OCT])
    |=> $stable(count[`MCC_IDX_TX_OCT]))
    else $error("masked transmit counter moved");

  // Octet sums and skipped frames
  a_rx_octet_vlan: assert property (
    (gate[`MCC_IDX_RX_OCT] && rx_good && rx_evt.vlan_strip && !wr_en[`MCC_IDX_RX_OCT])
    |=> count[`MCC_IDX_RX_OCT] == $past(count[`MCC_IDX_RX_OCT])
        + WIDTH'($past(rx_evt.octets)) + WIDTH'(`MCC_VLAN_OCTETS))
    else $error("received octets or tag not added");
  a_tx_octet_plain: assert property (
    (gate[`MCC_IDX_TX_OCT] && tx_good && !tx_evt.vlan_insert && !wr_en[`MCC_IDX_TX_OCT])
    |=> count[`MCC_IDX_TX_OCT] == $past(count[`MCC_IDX_TX_OCT])
        + WIDTH'($past(tx_evt.octets)))
    else $error("transmitted octets not added");
  a_rx_frame_skip: assert property (
    (rx_evt.valid && (!rx_evt.ok || rx_evt.len_err || rx_evt.align_err)
     && !wr_en[`MCC_IDX_RX_OCT]) |=> $stable(count[`MCC_IDX_RX_OCT]))
    else $error("bad or failed frame counted");
  a_tx_fail_skip: assert property (
    (tx_evt.valid && !tx_evt.ok && !wr_en[`MCC_IDX_TX_OCT])
    |=> $stable(count[`MCC_IDX_TX_OCT]))
    else $error("failed transmit frame counted");

  // Wrap instead of saturation
  a_rx_wrap: assert property (
    (inc_en[`MCC_IDX_RX_OCT] && !wr_en[`MCC_IDX_RX_OCT] && count[`MCC_IDX_RX_OCT] > ~rx_len)
    |=> count[`MCC_IDX_RX_OCT] < $past(count[`MCC_IDX_RX_OCT]))
    else $error("receive counter did not wrap");
  a_tx_wrap: assert property (
    (inc_en[`MCC_IDX_TX_OCT] && !wr_en[`MCC_IDX_TX_OCT] && count[`MCC_IDX_TX_OCT] > ~tx_len)
    |=> count[`MCC_IDX_TX_OCT] < $past(count[`MCC_IDX_TX_OCT]))
    else $error("transmit counter did not wrap");

  // Host writes and read answers
  a_write_rx: assert property (
    (wr_en[`MCC_IDX_RX_OCT] && !inc_en[`MCC_IDX_RX_OCT])
    |=> count[`MCC_IDX_RX_OCT] == $past(reg_wdata))
    else $error("host write to receive counter not stored");
  a_write_tx: assert property (
    (wr_en[`MCC_IDX_TX_OCT] && !inc_en[`MCC_IDX_TX_OCT])
    |=> count[`MCC_IDX_TX_OCT] == $past(reg_wdata))
    else $error("host write to transmit counter not stored");
  a_rvalid_pulse: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_idle: assert property (
    !reg_rd |=> (!reg_rvalid && reg_rdata == '0))
    else $error("read data outside a read answer");
  a_unmapped_zero: assert property (
    (reg_rd && !(|sel)) |=> reg_rdata == '0)
    else $error("unmapped read returned data");
endmodule

// ===== tb/mcc_stats_top_test.sv
// Self-checking bench for the collision and octet counters
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_stats_top_test;
  logic                      ref_clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      global_stats_enable = 1'b1;
  logic [2:0]                counter_mask_reg = 3'h0;
  mcc_pkg::mcc_tx_event_type tx_evt = '0;
  mcc_pkg::mcc_rx_event_type rx_evt = '0;
  logic [7:0]                reg_addr = 8'h00;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [31:0]               reg_wdata = 32'h0;
  logic [31:0]               reg_rdata;
  logic                      reg_rvalid;
  logic                      stats_harvest_flag;
  logic [31:0]               mdl [3] = '{default: 32'h0};
  logic [7:0]                ofs [3] = '{`MCC_OFS_COLL, `MCC_OFS_RX_OCT, `MCC_OFS_TX_OCT};
  logic [31:0]               exp_q [$];
  int                        mismatches = 0;
  int                        n_checks = 0;
  int                        exp_hw = 0;
  int                        n_hw = 0;
  int                        cyc = 0;
  integer                    seed = 32'hC640;

  mcc_stats_top #(.WIDTH(32)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .global_stats_enable(global_stats_enable), .counter_mask_reg(counter_mask_reg),
    .tx_evt(tx_evt), .rx_evt(rx_evt), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .stats_harvest_flag(stats_harvest_flag));

  always #5 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_hw(input string nm, input int e, input int g);
    n_checks++;
    if (g != e) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Model add with high-water crossing tracking
  task automatic bump(input int i, input logic [31:0] amt);
    logic [31:0] nv;
    nv = mdl[i] + amt;
    if (mdl[i] < `MCC_HIGH_WATER && nv >= `MCC_HIGH_WATER) exp_hw++;
    mdl[i] = nv;
  endtask

  // Write, then read the same offset back in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic mapped;
    mapped = 1'b0;
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (a == ofs[i]) begin
        mdl[i] = d;
        mapped = 1'b1;
      end
    end
    exp_q.push_back(mapped ? d : 32'h0);
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask

  task automatic rd_all();
    for (int i = 0; i < 3; i++) begin
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = ofs[i];
      exp_q.push_back(mdl[i]);
      @(negedge ref_clk);
      reg_rd = 1'b0;
    end
  endtask

  task automatic ev(input mcc_pkg::mcc_tx_event_type t, input mcc_pkg::mcc_rx_event_type r);
    logic on;
    @(negedge ref_clk);
    tx_evt = t;
    rx_evt = r;
    on = global_stats_enable;
    if (on && !counter_mask_reg[0] && t.valid && t.ok && t.coll_cnt >= `MCC_MIN_MULTI_COLL)
      bump(0, 32'h1);
    if (on && !counter_mask_reg[2] && t.valid && t.ok)
      bump(2, t.octets + (t.vlan_insert ? `MCC_VLAN_OCTETS : 32'h0));
    if (on && !counter_mask_reg[1] && r.valid && r.ok && r[21:17] == 5'h00)
      bump(1, r.octets + (r.vlan_strip ? `MCC_VLAN_OCTETS : 32'h0));
    @(negedge ref_clk);
    tx_evt = '0;
    rx_evt = '0;
  endtask

  // Read data scoreboard on settled outputs, harvest pulse count, hang limit
  always @(negedge ref_clk) begin
    cyc++;
    if (stats_harvest_flag === 1'b1) n_hw++;
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk_rd("reg_rvalid", 32'h0, 32'h1);
      else chk_rd("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    if (cyc == 5000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    mcc_pkg::mcc_tx_event_type t;
    mcc_pkg::mcc_rx_event_type r;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    rd_all();
    wr(8'h00, 32'h1234_5678);
    rd_all();
    for (int c = 0; c < 5; c++) ev({2'h3, c[4:0], 1'b1, 16'h0040}, '0);
    ev({2'h2, 5'h03, 1'b0, 16'h0040}, 24'h80_0010);
    for (int e = 0; e < 5; e++) ev('0, 24'hC0_0010 | (24'h20_0000 >> e));
    ev('0, 24'hC1_0010);
    rd_all();
    for (int m = 0; m < 4; m++) begin
      counter_mask_reg = 3'h1 << m;
      global_stats_enable = (m != 3);
      ev({2'h3, 5'h03, 1'b0, 16'h0020}, 24'hC0_0020);
      rd_all();
    end
    for (int k = 0; k < 16; k++) begin
      global_stats_enable = ($random(seed) & 7) != 0;
      counter_mask_reg = ($random(seed) & 1) ? 3'h0 : 3'($random(seed));
      t = 24'($random(seed));
      r = 24'($random(seed));
      t.valid = 1'b1;
      r.valid = 1'b1;
      if ($random(seed) & 1) r[22:17] = 6'h20;
      ev(t, r);
      rd_all();
    end
    // Mid-run reset clears every counter
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    mdl = '{default: 32'h0};
    rd_all();
    global_stats_enable = 1'b1;
    counter_mask_reg = 3'h0;
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], `MCC_HIGH_WATER - 32'h1);
      ev({2'h3, 5'h02, 1'b0, 16'h0001}, 24'hC0_0001);
      rd_all();
      chk_hw("harvest_pulses", exp_hw, n_hw);
    end
    for (int i = 0; i < 3; i++) wr(ofs[i], 32'hFFFF_FFFF);
    ev({2'h3, 5'h02, 1'b0, 16'h0001}, 24'hC0_0001);
    rd_all();
    repeat (4) @(negedge ref_clk);
    chk_hw("harvest_pulses", exp_hw, n_hw);
    chk_hw("pending_reads", 0, exp_q.size());
    finish_test();
  end
endmodule
